//--- sts_defs.svh
// register offsets, field positions and reset values of the status bank
// assumes inclusion by bare name from the package; the design modules use its macros without including it
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH

`define STS_ADDR_W         8
`define STS_DATA_W         8
`define STS_OFS_INT_HIGH   8'h08
`define STS_OFS_OP_STATE   8'h09
`define STS_RST_INT_HIGH   8'h50
`define STS_RST_OP_STATE   8'h41
`define STS_BIT_A_LOSS     0
`define STS_BIT_A_VIOL     1
`define STS_BIT_B_LOSS     2
`define STS_BIT_UNUSED     5
`define STS_BIT_EXT_ALARM  7
`define STS_INT_USED_MASK  8'hdf
`define STS_READ_NONE      8'h00

`endif

//--- sts_pkg.sv
// types shared by the status register bank modules
// assumes sts_defs.svh is on the include path
package sts_pkg;
`include "sts_defs.svh"

   typedef logic [`STS_DATA_W-1:0] sts_byte_t;
   typedef logic [`STS_ADDR_W-1:0] sts_addr_t;

   // register select decoded from the port address
   typedef enum logic [1:0] {
      STS_SEL_NONE     = 2'b00,
      STS_SEL_INT_HIGH = 2'b01,
      STS_SEL_OP_STATE = 2'b11
   } sts_sel_t;
endpackage

//--- sts_latch_if.sv
// carrier between the register bank and its sticky latch array
// assumes both ends run on the same clock
interface sts_latch_if;
   import sts_pkg::*;
   sts_byte_t set;   // event pulses, one per bit
   sts_byte_t clr;   // write-one-to-clear strobes
   sts_byte_t flag;  // latched flags

   modport bank  (output set, output clr, input flag);
   modport latch (input set, input clr, output flag);
endinterface

//--- sts_sticky_latch.sv
// array of sticky flags: set by events, cleared by writing one
// assumes set and clr come from logic on clk_i
module sts_sticky_latch
   import sts_pkg::*;
#(
   parameter int        WIDTH     = `STS_DATA_W,
   parameter sts_byte_t RST_VAL   = `STS_RST_INT_HIGH,
   parameter sts_byte_t USED_MASK = `STS_INT_USED_MASK
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   sts_latch_if.latch lt
);
   // one flop per bit; an event in the clear cycle keeps the bit set
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      logic flag_ff;
      logic nxt_flag;
      always_comb begin
         nxt_flag = flag_ff;
         if (lt.clr[g]) begin
            nxt_flag = 1'b0;
         end
         if (lt.set[g]) begin
            nxt_flag = 1'b1;
         end
      end
      always_ff @(posedge clk_i) begin
         if (!nrst_i) begin
            flag_ff <= RST_VAL[g] & USED_MASK[g];
         end else begin
            flag_ff <= nxt_flag & USED_MASK[g];
         end
      end
      assign lt.flag[g] = flag_ff;
   end
endmodule // sts_sticky_latch

//--- sts_status_bank.sv
// interrupt status (high byte) and operating state status registers
// assumes event and state inputs come from monitors on clk_i and a
// simple strobed microprocessor port: one-cycle rd/wr with address
module sts_status_bank
   import sts_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire sts_addr_t  addr_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire sts_byte_t  wdata_i,
   input  wire logic       line_in_a_signal_loss_i,
   input  wire logic       line_in_a_code_violation_i,
   input  wire logic       line_in_b_signal_loss_i,
   input  wire logic [4:0] upper_events_i,
   input  wire logic       ext_sync_monitor_alarm_i,
   input  wire logic [6:0] op_state_i,
   output logic            rvalid_o,
   output sts_byte_t       rdata_o,
   output sts_byte_t       int_flags_o
);
// Operation
// - line B signal loss sets bit 2
// - line A code violation sets bit 1
// - bits stay set until one written
// - read-only state register, resets to 0x41
// - bit 7 shows live sync monitor alarm

   // address decode shared by read and write paths
   function automatic sts_sel_t decode(input sts_addr_t a);
      unique case (a)
         `STS_OFS_INT_HIGH: decode = STS_SEL_INT_HIGH;
         `STS_OFS_OP_STATE: decode = STS_SEL_OP_STATE;
         default:           decode = STS_SEL_NONE;
      endcase
   endfunction

   sts_latch_if lt ();
   sts_byte_t   op_state_ff;
   logic        rvalid_ff;
   sts_byte_t   rdata_ff;
   sts_byte_t   int_flags_ff;

   // event pulses into the sticky array
   always_comb begin
      lt.set                     = '0;
      lt.set[`STS_BIT_A_LOSS]    = line_in_a_signal_loss_i;
      lt.set[`STS_BIT_A_VIOL]    = line_in_a_code_violation_i;
      lt.set[`STS_BIT_B_LOSS]    = line_in_b_signal_loss_i;
      lt.set[7:3]                = upper_events_i;
      lt.set[`STS_BIT_UNUSED]    = 1'b0;
   end

   // write-one-to-clear; zeros and writes elsewhere do nothing
   assign lt.clr = (wr_i && decode(addr_i) == STS_SEL_INT_HIGH) ? wdata_i : '0;

   sts_sticky_latch #(
      .WIDTH     (`STS_DATA_W),
      .RST_VAL   (`STS_RST_INT_HIGH),
      .USED_MASK (`STS_INT_USED_MASK)
   ) u_latch (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .lt     (lt)
   );

   // operating state: sampled every cycle, alarm bit unlatched
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         op_state_ff <= `STS_RST_OP_STATE;
      end else begin
         op_state_ff <= {ext_sync_monitor_alarm_i, op_state_i};
      end
   end

   // read port: data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= `STS_READ_NONE;
      end else begin
         rvalid_ff <= rd_i;
         if (rd_i) begin
            unique case (decode(addr_i))
               STS_SEL_INT_HIGH: rdata_ff <= lt.flag;
               STS_SEL_OP_STATE: rdata_ff <= op_state_ff;
               STS_SEL_NONE:     rdata_ff <= `STS_READ_NONE;
            endcase
         end
      end
   end

   // mirror of the latched flags for neighbouring logic
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         int_flags_ff <= `STS_RST_INT_HIGH;
      end else begin
         int_flags_ff <= lt.flag;
      end
   end

   assign rvalid_o    = rvalid_ff;
   assign rdata_o     = rdata_ff;
   assign int_flags_o = int_flags_ff;
endmodule // sts_status_bank

//--- sts_status_bank_monitor.sv
// checker for the status register bank ports
// assumes one clock domain with a synchronous active-low reset
module sts_status_bank_monitor
   import sts_pkg::*;
(
   input wire logic      clk_i,
   input wire logic      nrst_i,
   input wire sts_addr_t addr_i,
   input wire logic      wr_i,
   input wire logic      rd_i,
   input wire sts_byte_t wdata_i,
   input wire logic      line_in_a_signal_loss_i,
   input wire logic      line_in_a_code_violation_i,
   input wire logic      line_in_b_signal_loss_i,
   input wire logic      ext_sync_monitor_alarm_i,
   input wire logic      rvalid_o,
   input wire sts_byte_t rdata_o,
   input wire sts_byte_t int_flags_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // events reach the flag copy two edges later
   chk_b_loss_set: assert property (line_in_b_signal_loss_i |-> ##2 int_flags_o[2])
      else $error("b loss flag not set");
   chk_a_viol_set: assert property (line_in_a_code_violation_i |-> ##2 int_flags_o[1])
      else $error("a violation flag not set");
   chk_a_loss_set: assert property (line_in_a_signal_loss_i |-> ##2 int_flags_o[0])
      else $error("a loss flag not set");
   // a flag drops only after a one is written to it
   chk_flag_sticky: assert property ($fell(int_flags_o[0]) |->
      $past(wr_i && addr_i == 8'h08 && wdata_i[0], 2)) else $error("flag lost");
   chk_clear_one: assert property (wr_i && addr_i == 8'h08 && wdata_i[2]
      && !line_in_b_signal_loss_i |-> ##2 !int_flags_o[2]) else $error("flag kept");
   chk_read_answer: assert property (rd_i |=> rvalid_o) else $error("no answer");
   // alarm bit is live, two flops behind the monitor at the read data
   chk_alarm_live: assert property (rd_i && addr_i == 8'h09 && $past(nrst_i) |=>
      rdata_o[7] == $past(ext_sync_monitor_alarm_i, 2)) else $error("alarm bit wrong");
   cover property (rd_i && addr_i == 8'h09);
   cover property (wr_i && wdata_i[0]);
   cover property ($rose(int_flags_o[2]));
endmodule // sts_status_bank_monitor

bind sts_status_bank sts_status_bank_monitor i_sts_status_bank_monitor (.clk_i, .nrst_i,
   .addr_i, .wr_i, .rd_i, .wdata_i, .line_in_a_signal_loss_i, .line_in_a_code_violation_i,
   .line_in_b_signal_loss_i, .ext_sync_monitor_alarm_i, .rvalid_o, .rdata_o, .int_flags_o);

//--- sts_status_bank_bench.sv
// self-checking bench for the status register bank
// assumes reads answer one cycle after the strobe
module sts_status_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sts_pkg::*;
   logic      clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, alarm = 0, rvalid_o;
   logic [2:0] ev = 0;
   logic [6:0] op = 0;
   sts_addr_t addr_i = 0;
   sts_byte_t wdata_i = 0, rdata_o, int_flags_o, e;
   int        mismatches = 0, n_tests = 0;
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   sts_status_bank i_sts_status_bank (.clk_i, .nrst_i, .addr_i, .wr_i, .rd_i, .wdata_i,
      .line_in_a_signal_loss_i(ev[0]), .line_in_a_code_violation_i(ev[1]),
      .line_in_b_signal_loss_i(ev[2]), .upper_events_i(5'h0),
      .ext_sync_monitor_alarm_i(alarm), .op_state_i(op), .rvalid_o, .rdata_o, .int_flags_o);
   task automatic check(input sts_byte_t seen, input sts_byte_t exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input sts_addr_t a, input sts_byte_t v);
      @(posedge clk_i) begin addr_i <= a; wdata_i <= v; wr_i <= 1; end
      @(posedge clk_i) wr_i <= 0;
   endtask
   // read strobe, then judge the answer once it has settled
   task automatic rd(input sts_addr_t a, input sts_byte_t exp);
      @(posedge clk_i) begin addr_i <= a; rd_i <= 1; end
      @(posedge clk_i) rd_i <= 0;
      #1 check({7'h0, rvalid_o}, 8'h01);
      check(rdata_o, exp);
   endtask
   // set each event bit, then clear them one by one
   task automatic t_events;
      e = 8'h50;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i) ev[i] <= 1;
         @(posedge clk_i) ev[i] <= 0;
         e[i] = 1;
         rd(8'h08, e);
         check(int_flags_o, e);
      end
      wr(8'h08, 8'h00);
      rd(8'h08, e);
      for (int i = 0; i < 3; i++) begin
         wr(8'h08, 8'h01 << i);
         e[i] = 0;
         rd(8'h08, e);
      end
   endtask
   // event and clear in one cycle: the event wins, then a plain clear
   task automatic t_set_wins;
      @(posedge clk_i) begin ev[0] <= 1; addr_i <= 8'h08; wdata_i <= 8'h01; wr_i <= 1; end
      @(posedge clk_i) begin ev[0] <= 0; wr_i <= 0; end
      rd(8'h08, 8'h51);
      @(posedge clk_i) #1 check({7'h0, rvalid_o}, 8'h00);
      wr(8'h08, 8'h01);
      rd(8'h08, 8'h50);
      check(int_flags_o, 8'h50);
   endtask
   // live alarm follows the monitor; writes do not reach the state byte
   task automatic t_alarm;
      @(posedge clk_i) begin alarm <= 1; op <= 7'h41; end
      rd(8'h09, 8'hc1);
      wr(8'h09, 8'h00);
      @(posedge clk_i) alarm <= 0;
      rd(8'h09, 8'h41);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // reset, then the first read lands on the first edge after release
   initial begin
      repeat (2) @(posedge clk_i);
      @(posedge clk_i) begin nrst_i <= 1; rd_i <= 1; addr_i <= 8'h09; end
      @(posedge clk_i) rd_i <= 0;
      #1 check(rdata_o, 8'h41);
      rd(8'h09, 8'h00);
      t_events();
      t_set_wins();
      t_alarm();
      complete_run();
   end
   // watchdog against a hang
   initial begin
      #20000;
      mismatches++;
      complete_run();
   end
endmodule // sts_status_bank_bench
